// ### rtl/gsl_status.sv
// Purpose: gateway front panel: switches, status lights, error number, serial port
// Assumes: state, error and frame inputs come from the protocol engines, synchronous
// Notes: every output is registered; error number and error lights lag err_set_i by two cycles
`timescale 1ns/1ps
module gsl_status
    import gsl_pkg::*;
#(
    parameter int UART_DIV_CYC = UART_DIV,
    parameter int BLINK_HALF_CYC = BLINK_HALF,
    parameter logic [WARN_CNT_W-1:0] WARN_HOLD = WARN_CNT_W'(WARN_HOLD_CYC)
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_high_sw_i,
    input wire logic [3:0] addr_low_sw_i,
    input wire logic [7:0] dip_sw_i,
    input wire gsl_fb_state_t fb_state_i,
    input wire logic can_ready_i,
    input wire logic can_fault_i,
    input wire logic config_mode_i,
    input wire logic can_tx_done_i,
    input wire logic can_rx_done_i,
    input wire logic err_set_i,
    input wire logic [3:0] err_num_i,
    input wire logic [3:0] cfg_rate_i,
    input wire logic serial_receive_line_i,
    input wire gsl_byte_t cfg_tx_byte_i,
    output logic cfg_tx_ready_o,
    output logic serial_transmit_line_o,
    output gsl_byte_t cfg_rx_byte_o,
    output gsl_lights_t lights_o,
    output gsl_diag_t diag_o,
    output logic [7:0] station_addr_o,
    output logic station_addr_ok_o,
    output logic [5:0] can_node_o,
    output gsl_can_rate_t can_rate_o
);
    typedef struct packed {
        logic captured;
        logic [7:0] addr;
        logic addr_ok;
        logic [5:0] node;
        logic [1:0] dip_rate;
        gsl_can_rate_t rate;
        logic [3:0] err;
        logic [WARN_CNT_W-1:0] warn_cnt;
        logic [BLINK_CNT_W-1:0] blink_cnt;
        logic blink;
        logic rx_seen;
        logic [1:0] tx_cnt;
        logic [1:0] rx_cnt;
        gsl_lights_t lights;
        gsl_diag_t diag;
    } gsl_status_state_t;

    localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_HALF_CYC - 1);

    gsl_status_state_t state_reg;
    gsl_status_state_t state_next;
    logic serial_ferr;

    // receiver never gated by config_mode_i so the tool can connect at will
    gsl_uart #(.DIV(UART_DIV_CYC)) u_uart (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .serial_receive_line_i(serial_receive_line_i),
        .tx_byte_i(cfg_tx_byte_i),
        .tx_ready_o(cfg_tx_ready_o),
        .serial_transmit_line_o(serial_transmit_line_o),
        .rx_byte_o(cfg_rx_byte_o),
        .rx_frame_err_o(serial_ferr)
    );

    function automatic gsl_can_rate_t pick_rate(input logic [3:0] stored, input logic [1:0] dip);
        if (stored == CFG_RATE_DIP || stored > CFG_RATE_MAX) begin
            pick_rate = gsl_can_rate_t'({1'b0, dip});
        end else begin
            pick_rate = gsl_can_rate_t'(3'(stored - 4'h1));
        end
    endfunction : pick_rate

    function automatic logic [1:0] pair(input logic red, input logic green);
        pair = {red, green};
    endfunction : pair

    always_comb begin
        logic err_on;
        logic [3:0] new_err;
        logic take_err;
        err_on = 1'b0;
        new_err = err_num_i;
        take_err = 1'b0;
        state_next = state_reg;
        // sampled once after each reset; no input but reset_i rewrites the address later
        if (!state_reg.captured) begin
            state_next.captured = 1'b1;
            state_next.addr = {addr_high_sw_i, addr_low_sw_i};
            state_next.addr_ok = ({addr_high_sw_i, addr_low_sw_i} <= ADDR_MAX);
            state_next.node = dip_sw_i[7:2];
            state_next.dip_rate = {dip_sw_i[0], dip_sw_i[1]};
        end
        state_next.rate = pick_rate(cfg_rate_i, state_reg.dip_rate);
        // blink base
        if (state_reg.blink_cnt == '0) begin
            state_next.blink_cnt = BLINK_LAST;
            state_next.blink = !state_reg.blink;
        end else begin
            state_next.blink_cnt = state_reg.blink_cnt - 1'b1;
        end
        // error store; a serious error is never displaced
        if (err_set_i && err_num_i != ERR_NONE) begin
            take_err = 1'b1;
        end else if (serial_ferr) begin
            take_err = 1'b1;
            new_err = ERR_SERIAL;
        end
        if (state_reg.err > ERR_NONE && state_reg.err <= ERR_SERIOUS_MAX) begin
            take_err = 1'b0;
        end
        if (take_err) begin
            state_next.err = new_err;
            state_next.warn_cnt = WARN_HOLD;
        end else if (state_reg.err > ERR_SERIOUS_MAX) begin
            if (state_reg.warn_cnt <= 1) state_next.err = ERR_NONE;
            state_next.warn_cnt = state_reg.warn_cnt - 1'b1;
        end
        if (can_rx_done_i) begin
            state_next.rx_seen = 1'b1;
            state_next.rx_cnt = state_reg.rx_cnt + 2'h1;
        end
        if (can_tx_done_i) state_next.tx_cnt = state_reg.tx_cnt + 2'h1;
        // lights
        err_on = (state_reg.err != ERR_NONE);
        state_next.lights.fb_err = (fb_state_i != FB_DATA_EXCH);
        // fb_state_i comes from the autobauding engine, so no rate setting here
        case (fb_state_i)
            FB_DATA_EXCH: state_next.lights.fb_state = LIGHT_GREEN;
            FB_WAIT_CFG: state_next.lights.fb_state = pair(1'b0, state_reg.blink);
            FB_WAIT_PRM: state_next.lights.fb_state = pair(!state_reg.blink, state_reg.blink);
            FB_FAULT: state_next.lights.fb_state = LIGHT_RED;
            default: state_next.lights.fb_state = LIGHT_RED;
        endcase
        if (config_mode_i) begin
            state_next.lights.can_state = pair(!state_reg.blink, state_reg.blink);
            state_next.lights.fault_code = state_reg.blink ? CFG_PATTERN : ~CFG_PATTERN;
        end else if (err_on || can_fault_i) begin
            state_next.lights.can_state = LIGHT_RED;
            state_next.lights.fault_code = state_reg.blink ? state_reg.err : 4'h0;
        end else begin
            if (state_reg.rx_seen) begin
                state_next.lights.can_state = LIGHT_GREEN;
            end else if (can_ready_i) begin
                state_next.lights.can_state = pair(1'b0, state_reg.blink);
            end else begin
                state_next.lights.can_state = LIGHT_OFF;
            end
            state_next.lights.fault_code = {state_reg.rx_cnt, state_reg.tx_cnt};
        end
        state_next.diag.len = DIAG_LEN;
        state_next.diag.err_num = state_reg.err;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
            state_reg.addr <= ADDR_RST;
            state_reg.rate <= RATE_1M;
            state_reg.lights.fb_err <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign lights_o = state_reg.lights;
    assign diag_o = state_reg.diag;
    assign station_addr_o = state_reg.addr;
    assign station_addr_ok_o = state_reg.addr_ok;
    assign can_node_o = state_reg.node;
    assign can_rate_o = state_reg.rate;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_fb_err_light: assert property ((fb_state_i != FB_DATA_EXCH) |=> lights_o.fb_err)
        else $error("fieldbus error light off outside data exchange");
    a_fb_green_dx: assert property ((fb_state_i == FB_DATA_EXCH) |=> !lights_o.fb_err
        && lights_o.fb_state == LIGHT_GREEN)
        else $error("fieldbus light not steady green in data exchange");
    a_can_red_err: assert property (!config_mode_i && state_reg.err != ERR_NONE
        |=> lights_o.can_state == LIGHT_RED)
        else $error("CAN light not red while an error is shown");
    a_diag_bound: assert property (1'b1 |=> diag_o.len <= DIAG_MAX && diag_o.len != 4'h0
        && diag_o.err_num == $past(state_reg.err))
        else $error("diagnostic length or error number wrong");
    a_addr_frozen: assert property (state_reg.captured |=> $stable(station_addr_o))
        else $error("station address changed after power-up");
    a_addr_range: assert property ($rose(state_reg.captured)
        |-> station_addr_ok_o == (station_addr_o <= ADDR_MAX))
        else $error("address valid flag wrong");
    // the switch code is the one captured at power-up, not the live switch
    a_rate_dip: assert property (state_reg.captured && cfg_rate_i == CFG_RATE_DIP
        |=> can_rate_o == gsl_can_rate_t'({1'b0, state_reg.dip_rate}))
        else $error("DIP rate code not applied");
    a_serious_latch: assert property (state_reg.err > ERR_NONE
        && state_reg.err <= ERR_SERIOUS_MAX |=> $stable(state_reg.err))
        else $error("serious error did not stay latched");
    a_blink_period: assert property ($changed(state_reg.blink)
        |-> $past(state_reg.blink_cnt) == '0)
        else $error("blink toggled off its period");
    a_tx_wrap: assert property (can_tx_done_i && state_reg.tx_cnt == 2'h3
        |=> state_reg.tx_cnt == 2'h0)
        else $error("transmit count did not wrap");
    a_ferr_warn: assert property (serial_ferr && !err_set_i && (state_reg.err == ERR_NONE
        || state_reg.err > ERR_SERIOUS_MAX) |=> state_reg.err == ERR_SERIAL)
        else $error("serial framing fault not raised as warning");

    c_warn_clear: cover property (state_reg.err > ERR_SERIOUS_MAX ##1 state_reg.err == ERR_NONE);
    c_cfg_mode: cover property (config_mode_i ##1 lights_o.can_state == LIGHT_RED);
    c_prm_wait: cover property (fb_state_i == FB_WAIT_PRM ##1 lights_o.fb_state == LIGHT_RED);
endmodule : gsl_status

// ### rtl/gsl_pkg.sv
// Purpose: shared constants and types of the gateway switch and light logic
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: light pairs are coded {red, green}
package gsl_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int UART_BAUD = 9600;
    // bit time rounded down: 9600 baud is 10416.67 cycles, error 0.006 %
    localparam int UART_DIV = CLK_HZ / UART_BAUD;
    localparam int UART_CNT_W = 14;
    localparam logic [2:0] UART_LAST_BIT = 3'h7;
    localparam int BLINK_HZ = 2;
    localparam int BLINK_HALF = CLK_HZ / (2 * BLINK_HZ);
    localparam int BLINK_CNT_W = 25;
    localparam longint WARN_HOLD_S = 60;
    localparam longint WARN_HOLD_CYC = WARN_HOLD_S * longint'(CLK_HZ);
    localparam int WARN_CNT_W = 33;
    localparam logic [7:0] ADDR_MAX = 8'h7D;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [3:0] DIAG_LEN = 4'h1;
    localparam logic [3:0] DIAG_MAX = 4'h8;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_SERIOUS_MAX = 4'h5;
    localparam logic [3:0] ERR_SERIAL = 4'h9;
    localparam logic [3:0] CFG_RATE_DIP = 4'h0;
    localparam logic [3:0] CFG_RATE_MAX = 4'h8;
    localparam logic [1:0] LIGHT_OFF = 2'h0;
    localparam logic [1:0] LIGHT_GREEN = 2'h1;
    localparam logic [1:0] LIGHT_RED = 2'h2;
    localparam logic [3:0] CFG_PATTERN = 4'h5;

    typedef enum logic [1:0] {FB_DATA_EXCH, FB_WAIT_CFG, FB_WAIT_PRM, FB_FAULT} gsl_fb_state_t;
    typedef enum logic [2:0] {
        RATE_1M, RATE_500K, RATE_250K, RATE_125K, RATE_100K, RATE_50K, RATE_20K, RATE_10K
    } gsl_can_rate_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } gsl_byte_t;

    typedef struct packed {
        logic fb_err;
        logic [1:0] fb_state;
        logic [1:0] can_state;
        logic [3:0] fault_code;
    } gsl_lights_t;

    typedef struct packed {
        logic [3:0] len;
        logic [3:0] err_num;
    } gsl_diag_t;
endpackage : gsl_pkg

// ### rtl/gsl_uart.sv
// Purpose: serial configuration port, 8 data bits, no parity, 1 stop bit
// Assumes: serial_receive_line_i synchronous to ref_clk_i, idle high
// Notes: lsb first; receiver always runs so the tool may connect at any time
`timescale 1ns/1ps
module gsl_uart
    import gsl_pkg::*;
#(
    parameter int DIV = UART_DIV
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic serial_receive_line_i,
    input wire gsl_byte_t tx_byte_i,
    output logic tx_ready_o,
    output logic serial_transmit_line_o,
    output gsl_byte_t rx_byte_o,
    output logic rx_frame_err_o
);
    typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} gsl_uart_st_t;
    typedef struct packed {
        gsl_uart_st_t rx_st;
        logic [UART_CNT_W-1:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        gsl_byte_t rx_out;
        logic rx_ferr;
        gsl_uart_st_t tx_st;
        logic [UART_CNT_W-1:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_line;
        logic tx_ready;
    } gsl_uart_state_t;

    localparam logic [UART_CNT_W-1:0] BIT_LAST = UART_CNT_W'(DIV - 1);
    localparam logic [UART_CNT_W-1:0] HALF_LAST = UART_CNT_W'(DIV / 2 - 1);

    gsl_uart_state_t state_reg;
    gsl_uart_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.rx_out.valid = 1'b0;
        state_next.rx_ferr = 1'b0;
        if (state_reg.rx_cnt != '0) state_next.rx_cnt = state_reg.rx_cnt - 1'b1;
        if (state_reg.tx_cnt != '0) state_next.tx_cnt = state_reg.tx_cnt - 1'b1;
        case (state_reg.rx_st)
            U_IDLE: begin
                if (!serial_receive_line_i) begin
                    state_next.rx_st = U_START;
                    state_next.rx_cnt = HALF_LAST;
                end
            end
            U_START: begin
                if (state_reg.rx_cnt == '0) begin
                    // glitch shorter than half a bit is dropped
                    state_next.rx_st = serial_receive_line_i ? U_IDLE : U_DATA;
                    state_next.rx_cnt = BIT_LAST;
                    state_next.rx_bit = 3'h0;
                end
            end
            U_DATA: begin
                if (state_reg.rx_cnt == '0) begin
                    state_next.rx_sh = {serial_receive_line_i, state_reg.rx_sh[7:1]};
                    state_next.rx_bit = state_reg.rx_bit + 3'h1;
                    state_next.rx_cnt = BIT_LAST;
                    if (state_reg.rx_bit == UART_LAST_BIT) state_next.rx_st = U_STOP;
                end
            end
            U_STOP: begin
                if (state_reg.rx_cnt == '0) begin
                    state_next.rx_st = U_IDLE;
                    state_next.rx_out.data = state_reg.rx_sh;
                    state_next.rx_out.valid = serial_receive_line_i;
                    state_next.rx_ferr = !serial_receive_line_i;
                end
            end
            default: state_next.rx_st = U_IDLE;
        endcase
        case (state_reg.tx_st)
            U_IDLE: begin
                if (tx_byte_i.valid && state_reg.tx_ready) begin
                    state_next.tx_sh = tx_byte_i.data;
                    state_next.tx_line = 1'b0;
                    state_next.tx_ready = 1'b0;
                    state_next.tx_cnt = BIT_LAST;
                    state_next.tx_st = U_START;
                end
            end
            U_START, U_DATA: begin
                if (state_reg.tx_cnt == '0) begin
                    state_next.tx_cnt = BIT_LAST;
                    if (state_reg.tx_st == U_DATA && state_reg.tx_bit == UART_LAST_BIT) begin
                        state_next.tx_line = 1'b1;
                        state_next.tx_st = U_STOP;
                    end else begin
                        state_next.tx_line = state_reg.tx_sh[0];
                        state_next.tx_sh = {1'b0, state_reg.tx_sh[7:1]};
                        state_next.tx_bit = (state_reg.tx_st == U_START) ? 3'h0
                            : state_reg.tx_bit + 3'h1;
                        state_next.tx_st = U_DATA;
                    end
                end
            end
            U_STOP: begin
                if (state_reg.tx_cnt == '0) begin
                    state_next.tx_st = U_IDLE;
                    state_next.tx_ready = 1'b1;
                end
            end
            default: state_next.tx_st = U_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
            state_reg.rx_st <= U_IDLE;
            state_reg.tx_st <= U_IDLE;
            state_reg.tx_line <= 1'b1;
            state_reg.tx_ready <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tx_ready_o = state_reg.tx_ready;
    assign serial_transmit_line_o = state_reg.tx_line;
    assign rx_byte_o = state_reg.rx_out;
    assign rx_frame_err_o = state_reg.rx_ferr;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_tx_start_bit: assert property (tx_byte_i.valid && tx_ready_o
        |=> !serial_transmit_line_o)
        else $error("tx start bit not driven low");
    a_rx_stop_check: assert property (rx_byte_o.valid |-> $past(serial_receive_line_i))
        else $error("byte accepted without a high stop bit");
    c_rx_byte: cover property (rx_byte_o.valid);
endmodule : gsl_uart

// ### dv/gsl_cfg_pc.sv
// Purpose: configuration PC model on the serial port
// Assumes: bit time of DIV clock cycles, line idles high
// Notes: frames are 1 start, 8 data lsb first, 1 stop
`timescale 1ns/1ps
module gsl_cfg_pc #(
    parameter int DIV = 16
) (
    input wire logic ref_clk_i,
    input wire logic tx_line_i,
    output logic rx_line_o
);
    initial rx_line_o = 1'b1;
    // stop low only when a framing fault is wanted
    task automatic put(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line_o <= f[i];
            repeat (DIV) @(posedge ref_clk_i);
        end
        if (!stop) begin
            rx_line_o <= 1'b1;
            @(posedge ref_clk_i);
        end
    endtask : put
    task automatic get(output logic [7:0] d, output logic stop);
        int n;
        n = 0;
        while (tx_line_i !== 1'b0 && n < 100) begin
            @(posedge ref_clk_i);
            n++;
        end
        repeat (DIV / 2) @(posedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge ref_clk_i);
            d[i] = tx_line_i;
        end
        repeat (DIV) @(posedge ref_clk_i);
        stop = tx_line_i;
    endtask : get
endmodule : gsl_cfg_pc

// ### dv/tb_gsl_status.sv
// Purpose: self-checking bench of the front panel logic
// Assumes: short blink, warning and bit-time parameters
// Notes: outputs are read at the edge, so they show the previous cycle
`timescale 1ns/1ps
module tb_gsl_status;
    import gsl_pkg::*;
    localparam int DIV = 16;
    localparam int HALF = 4;
    localparam int HOLD = 20;
    localparam logic [3:0] FBX [4] = '{4'h2, 4'h3, 4'h6, 4'h4};
    logic ref_clk_i;
    logic reset_i = 1'b1;
    logic [3:0] addr_high_sw_i = '0, addr_low_sw_i = '0, err_num_i = '0, cfg_rate_i = '0;
    logic [7:0] dip_sw_i = '0;
    gsl_fb_state_t fb_state_i = FB_DATA_EXCH;
    logic can_ready_i = 0, can_fault_i = 0, config_mode_i = 0;
    logic can_tx_done_i = 0, can_rx_done_i = 0, err_set_i = 0;
    logic serial_receive_line_i, cfg_tx_ready_o, serial_transmit_line_o, station_addr_ok_o;
    gsl_byte_t cfg_tx_byte_i = '0;
    gsl_byte_t cfg_rx_byte_o;
    gsl_lights_t lights_o;
    gsl_diag_t diag_o;
    logic [7:0] station_addr_o;
    logic [5:0] can_node_o;
    gsl_can_rate_t can_rate_o;
    int err_total = 0;
    int num_checks = 0;
    logic [7:0] rx_q[$];
    logic [3:0] fbm, csm;
    logic [15:0] fcm;

    gsl_status #(.UART_DIV_CYC(DIV), .BLINK_HALF_CYC(HALF), .WARN_HOLD(WARN_CNT_W'(HOLD)))
    i_dut (.ref_clk_i, .reset_i, .addr_high_sw_i, .addr_low_sw_i, .dip_sw_i, .fb_state_i,
        .can_ready_i, .can_fault_i, .config_mode_i, .can_tx_done_i, .can_rx_done_i,
        .err_set_i, .err_num_i, .cfg_rate_i, .serial_receive_line_i, .cfg_tx_byte_i,
        .cfg_tx_ready_o, .serial_transmit_line_o, .cfg_rx_byte_o, .lights_o, .diag_o,
        .station_addr_o, .station_addr_ok_o, .can_node_o, .can_rate_o);
    gsl_cfg_pc #(.DIV(DIV)) pc (.ref_clk_i, .tx_line_i(serial_transmit_line_o),
        .rx_line_o(serial_receive_line_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (cfg_rx_byte_o.valid === 1'b1) rx_q.push_back(cfg_rx_byte_o.data);
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    // one mask bit per value seen, so blink phases need no exact alignment
    task watch(input int n);
        fbm = '0;
        csm = '0;
        fcm = '0;
        repeat (n) begin
            @(posedge ref_clk_i);
            fbm[lights_o.fb_state] = 1'b1;
            csm[lights_o.can_state] = 1'b1;
            fcm[lights_o.fault_code] = 1'b1;
        end
    endtask : watch
    task do_reset();
        reset_i <= 1'b1;
        tick(4);
        check("tx idle", serial_transmit_line_o, 1'b1);
        check("fb err rst", lights_o.fb_err, 1'b1);
        reset_i <= 1'b0;
        tick(4);
    endtask : do_reset
    task pulse_err(input logic [3:0] n);
        err_num_i <= n;
        err_set_i <= 1'b1;
        tick(1);
        err_set_i <= 1'b0;
    endtask : pulse_err
    task dut_send(input logic [7:0] d);
        logic [7:0] got;
        logic sb;
        fork
            pc.get(got, sb);
            begin
                cfg_tx_byte_i <= {1'b1, d};
                do @(posedge ref_clk_i); while (cfg_tx_ready_o !== 1'b1);
                cfg_tx_byte_i <= {1'b0, d};
                @(posedge ref_clk_i);
                check("tx busy", cfg_tx_ready_o, 1'b0);
            end
        join
        check("tx data", got, d);
        check("tx stop", sb, 1'b1);
        while (cfg_tx_ready_o !== 1'b1) @(posedge ref_clk_i);
    endtask : dut_send

    initial begin
        tick(10000);
        err_total++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            addr_high_sw_i <= 4'h7;
            addr_low_sw_i <= 4'hC + 4'(i);
            dip_sw_i <= {6'h2A ^ 6'(i), 2'(i)};
            do_reset();
            check("addr", station_addr_o, 8'h7C + 8'(i));
            check("addr ok", station_addr_ok_o, i < 2);
            check("node", can_node_o, 6'h2A ^ 6'(i));
            check("rate", can_rate_o, {i[0], i[1]});
        end
        addr_high_sw_i <= 4'h1;
        dip_sw_i <= 8'h00;
        tick(4);
        check("addr held", station_addr_o, 8'h7F);
        check("rate held", can_rate_o, RATE_125K);
        cfg_rate_i <= 4'h6;
        tick(3);
        check("stored rate", can_rate_o, RATE_50K);
        cfg_rate_i <= 4'h0;
        tick(3);
        check("dip rate", can_rate_o, RATE_125K);
        for (int s = 0; s < 4; s++) begin
            fb_state_i <= gsl_fb_state_t'(s);
            tick(3);
            watch(10);
            check("fb err", lights_o.fb_err, s != 0);
            check("fb light", fbm, FBX[s]);
        end
        fb_state_i <= FB_DATA_EXCH;
        config_mode_i <= 1'b1;
        tick(3);
        watch(10);
        check("cfg light", csm, 4'h6);
        check("cfg pattern", fcm, 16'h0420);
        config_mode_i <= 1'b0;
        can_ready_i <= 1'b1;
        tick(3);
        watch(10);
        check("ready light", csm, 4'h3);
        check("zero counts", fcm, 16'h0001);
        can_fault_i <= 1'b1;
        tick(3);
        watch(10);
        check("fault light", csm, 4'h4);
        can_fault_i <= 1'b0;
        can_tx_done_i <= 1'b1;
        can_rx_done_i <= 1'b1;
        tick(3);
        can_rx_done_i <= 1'b0;
        tick(2);
        can_tx_done_i <= 1'b0;
        tick(3);
        watch(10);
        check("active light", csm, 4'h2);
        check("counts", fcm, 16'h2000);
        pulse_err(4'h7);
        tick(2);
        watch(8);
        check("err light", csm, 4'h4);
        check("err flash", fcm, 16'h0081);
        check("diag num", diag_o.err_num, 4'h7);
        check("diag len", diag_o.len, DIAG_LEN);
        tick(30);
        check("warn gone", diag_o.err_num, ERR_NONE);
        watch(8);
        check("counts back", fcm, 16'h2000);
        pc.put(8'hA5, 1'b1);
        pc.put(8'h5A, 1'b1);
        pc.put(8'hFF, 1'b0);
        // the framing warning only stands for HOLD cycles after the bad stop bit
        tick(2);
        check("rx count", rx_q.size(), 2);
        check("rx byte a", rx_q[0], 8'hA5);
        check("rx byte b", rx_q[1], 8'h5A);
        check("frame warn", diag_o.err_num, ERR_SERIAL);
        dut_send(8'h3C);
        dut_send(8'hC3);
        tick(30);
        pulse_err(4'h3);
        tick(40);
        check("err latched", diag_o.err_num, 4'h3);
        pulse_err(4'h9);
        tick(3);
        check("err kept", diag_o.err_num, 4'h3);
        close_out();
    end
endmodule : tb_gsl_status
